// ---- logic/rsdmc_basis.sv ----
// Fixed GF(2) matrix map between conventional and dual basis symbols
module rsdmc_basis
   import rsdmc_pkg::*;
(
   // Symbol in and out
   input  wire logic [SYM_W-1:0] sym_in,
   output logic      [SYM_W-1:0] sym_out
);

   // ==========================================================
   // Each output bit is the parity of one masked matrix row
   always_comb begin
      for (int i = 0; i < SYM_W; i++) begin
         sym_out[i] = ^(BASIS_M[i] & sym_in);
      end
   end

endmodule

// ---- logic/rsdmc_chan_seq.sv ----
// Channel and symbol position counter shared by all channels
module rsdmc_chan_seq
   import rsdmc_pkg::*;
(
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Control
   input  wire logic             adv,
   input  wire logic             restart,
   // Position
   output logic      [CH_W-1:0]  ch_idx,
   output logic      [POS_W-1:0] pos,
   output logic                  blk_first,
   output logic                  blk_end
);

   typedef struct packed {
      logic [CH_W-1:0]  ch;
      logic [POS_W-1:0] pos;
   } rsdmc_seq_s;

   rsdmc_seq_s q;
   rsdmc_seq_s d;

   // ==========================================================
   // Next position; one counter serves every channel
   always_comb begin
      d = q;
      if (restart) begin
         d = '0;
      end else if (adv) begin
         if (q.ch == CH_W'(NUM_CH - 1)) begin
            d.ch = '0;
            d.pos = (q.pos == POS_W'(BLK_N - 1)) ? '0 : q.pos + 1'b1;
         end else begin
            d.ch = q.ch + 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign ch_idx    = q.ch;
   assign pos       = q.pos;
   assign blk_first = (q.ch == '0) && (q.pos == '0);
   assign blk_end   = (q.ch == CH_W'(NUM_CH - 1)) && (q.pos == POS_W'(BLK_N - 1));

   // ==========================================================
   // Checks
   a_chan_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
      adv && !restart && ch_idx == CH_W'(NUM_CH - 1) |=> ch_idx == '0)
      else $error("channel index did not wrap");
   a_chan_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !adv && !restart |=> $stable(ch_idx) && $stable(pos))
      else $error("position moved without a handshake");
   a_block_all: assert property (@(posedge aclk) disable iff (!aresetn)
      adv && blk_end |=> blk_first)
      else $error("block did not restart on all channels");

endmodule

// ---- logic/rsdmc_pkg.sv ----
// Shared constants, types and helpers of the multichannel decoder stream shell
package rsdmc_pkg;

   // ==========================================================
   // Code definition
   localparam int SYM_W      = 8;
   localparam int NUM_CH     = 3;
   localparam int BLK_N      = 255;
   localparam int DATA_K     = 239;
   localparam int CHK_R      = BLK_N - DATA_K;
   localparam int FIELD_POLY = 0;
   localparam int SCALE_H    = 1;
   localparam int GEN_START  = 0;
   localparam int NUM_PUNC   = 2;
   localparam int PD_SINGLE  = 203;
   localparam int CH_W       = $clog2(NUM_CH);
   localparam int POS_W      = $clog2(BLK_N);
   localparam int PSEL_W     = 1;

   // ==========================================================
   // Helpers evaluated at elaboration
   function automatic int default_poly(input int w);
      case (w)
         3:       return 11;
         4:       return 19;
         5:       return 37;
         6:       return 67;
         7:       return 137;
         8:       return 285;
         9:       return 529;
         10:      return 1033;
         11:      return 2053;
         12:      return 4179;
         default: return 0;
      endcase
   endfunction

   function automatic int gcd(input int a, input int b);
      int x;
      int y;
      int t;
      x = a;
      y = b;
      while (y != 0) begin
         t = x % y;
         x = y;
         y = t;
      end
      return x;
   endfunction

   localparam int POLY_USED = (FIELD_POLY == 0) ? default_poly(SYM_W) : FIELD_POLY;
   localparam bit SCALE_OK  = (gcd(SCALE_H, (1 << SYM_W) - 1) == 1);
   localparam int PD_MULTI  = PD_SINGLE * NUM_CH;
   localparam bit CONT_OK   = (PD_MULTI <= BLK_N * NUM_CH);

   // ==========================================================
   // Register map, byte addresses
   localparam int                ADDR_W   = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STAT = 8'h04;
   localparam logic [ADDR_W-1:0] REG_POLY = 8'h08;
   localparam logic [ADDR_W-1:0] REG_GEN  = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_PDLY = 8'h10;
   localparam logic [ADDR_W-1:0] REG_CODE = 8'h14;
   localparam logic [ADDR_W-1:0] REG_BLKS = 8'h18;
   localparam int CTRL_CCSDS   = 0;
   localparam int CTRL_RESTART = 1;
   localparam logic CCSDS_RST  = 1'b0;
   localparam int STAT_CH      = 8;
   localparam int STAT_PEND    = 16;
   localparam int STAT_PSEL    = 24;
   localparam int GEN_SCALE    = 16;
   localparam int PDLY_SCALEOK = 30;
   localparam int PDLY_CONTOK  = 31;
   localparam int CODE_R       = 16;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ==========================================================
   // Trailing symbols erased by each puncture pattern
   localparam logic [POS_W-1:0] PUNC_TAIL [NUM_PUNC] = '{8'h00, 8'h04};
   // Basis conversion matrix, row i selects the bits feeding output bit i
   localparam logic [SYM_W-1:0][SYM_W-1:0] BASIS_M = 64'h0102040810204080;

   // ==========================================================
   // Stream payloads
   typedef struct packed {
      logic             erase;
      logic [SYM_W-1:0] sym;
   } rsdmc_in_s;

   typedef struct packed {
      logic [CH_W-1:0]  ch;
      logic             erase;
      logic [SYM_W-1:0] sym;
   } rsdmc_out_s;

endpackage

// ---- logic/rsdmc_top.sv ----
// Multichannel Reed-Solomon decoder stream shell with AXI4-Lite registers
//
// Operation
// - Multichannel build has fixed n and r; all channels share code parameters.
// - A new block on one channel starts a new block on all channels.
// - One puncture selection per block on control stream applies to every channel.
// - Input symbols interlace channel 1, 2, ...; index moves only on handshake.
// - Output symbols leave in the same channel-interlaced order as input.
// - Input valid may drop any cycle; nothing sampled, channel index holds.
// - Erasure flag is per symbol and affects only that channel's symbol.
// - Multichannel delay is single delay times channels; must fit n times channels.
// - Field polynomial is an integer whose bit i is the x^i coefficient.
// - Polynomial value zero selects the default polynomial for the symbol width.
// - Defaults per width 3..12: 11,19,37,67,137,285,529,1033,2053,4179.
// - Generator roots are alpha^(h*(start+i)); any start value accepted.
// - For shortened codes block length is the shortened symbol count.
// - Largest check count equals block length minus data symbol count.
// - Only supported check counts may be supplied; others decode wrongly.
// - CCSDS mode applies dual-basis conversion at input and output.
// - Symbol width sets both input and output symbol field widths.
// - Without a per-block count field every block uses n minus k checks.
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
module rsdmc_top
   import rsdmc_pkg::*;
(
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic      [1:0]        s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic      [31:0]       s_axi_rdata,
   output logic      [1:0]        s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Per-block control stream
   input  wire logic [PSEL_W-1:0] puncture_pattern_select,
   input  wire logic              s_axis_ctrl_tvalid,
   output logic                   s_axis_ctrl_tready,
   // Interlaced input stream
   input  rsdmc_in_s              s_axis_input_tdata,
   input  wire logic              s_axis_input_tvalid,
   output logic                   s_axis_input_tready,
   // Interlaced output stream
   output rsdmc_out_s             m_axis_output_tdata,
   output logic                   m_axis_output_tvalid,
   output logic                   m_axis_output_tlast,
   input  wire logic              m_axis_output_tready
);

   // ==========================================================
   // State
   typedef struct packed {
      logic                  awready;
      logic                  wready;
      logic                  aw_have;
      logic                  w_have;
      logic [ADDR_W-1:0]     awaddr;
      logic [31:0]           wdata;
      logic [3:0]            wstrb;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  arready;
      logic                  rvalid;
      logic [1:0]            rresp;
      logic [31:0]           rdata;
      logic                  ccsds;
      logic                  restart;
      logic                  pend_have;
      logic [PSEL_W-1:0]     pend_psel;
      logic [PSEL_W-1:0]     blk_psel;
      logic                  ctrl_ready;
      logic                  in_ready;
      rsdmc_out_s [1:0]      obuf;
      logic [1:0]            olast;
      logic [1:0]            cnt;
      logic                  ovalid;
      logic [15:0]           blocks;
   } rsdmc_state_s;

   rsdmc_state_s q;
   rsdmc_state_s d;

   logic [CH_W-1:0]  seq_ch;
   logic [POS_W-1:0] seq_pos;
   logic             seq_first;
   logic             seq_end;
   logic [SYM_W-1:0] sym_dual;
   logic [SYM_W-1:0] sym_back;
   logic             acc;
   logic             pop;

   // Address decode shared by read and write
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      case (a)
         REG_CTRL, REG_STAT, REG_POLY, REG_GEN,
         REG_PDLY, REG_CODE, REG_BLKS: return 1'b1;
         default:                      return 1'b0;
      endcase
   endfunction

   // Trailing check symbols of the block erased by the chosen pattern
   function automatic logic punctured(input logic [POS_W-1:0] p,
                                      input logic [PSEL_W-1:0] s);
      if (NUM_PUNC == 0) begin
         return 1'b0;
      end
      return (PUNC_TAIL[s] != '0) && (p >= POS_W'(BLK_N) - PUNC_TAIL[s]);
   endfunction

   // ==========================================================
   // Shared channel sequencer and basis conversion
   rsdmc_chan_seq u_seq (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .adv       (acc),
      .restart   (q.restart),
      .ch_idx    (seq_ch),
      .pos       (seq_pos),
      .blk_first (seq_first),
      .blk_end   (seq_end)
   );

   rsdmc_basis u_to_dual (
      .sym_in  (s_axis_input_tdata.sym),
      .sym_out (sym_dual)
   );

   rsdmc_basis u_from_dual (
      .sym_in  (sym_dual),
      .sym_out (sym_back)
   );

   assign acc = s_axis_input_tvalid && q.in_ready;
   assign pop = q.ovalid && m_axis_output_tready;

   // ==========================================================
   // Next state
   always_comb begin
      logic [PSEL_W-1:0] eff_psel;
      logic [1:0]        slot;
      logic              fst_nxt;
      logic              need_ctrl;
      rsdmc_out_s        ent;
      d = q;
      eff_psel = '0;
      slot = '0;
      fst_nxt = 1'b0;
      need_ctrl = 1'b0;
      ent = '0;
      d.restart = 1'b0;

      // Write address and data captured in either order
      if (s_axi_awvalid && q.awready) begin
         d.aw_have = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_have = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (d.aw_have && d.w_have && !d.bvalid) begin
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = is_mapped(d.awaddr) ? RESP_OKAY : RESP_SLVERR;
         // Only the control word is writable; other words ignore writes
         if (d.awaddr == REG_CTRL && d.wstrb[0]) begin
            d.ccsds = d.wdata[CTRL_CCSDS];
            d.restart = d.wdata[CTRL_RESTART];
         end
      end
      d.awready = !d.aw_have && !d.bvalid;
      d.wready = !d.w_have && !d.bvalid;

      // Read path, one outstanding read
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && q.arready) begin
         d.rvalid = 1'b1;
         d.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         d.rdata = '0;
         case (s_axi_araddr)
            REG_CTRL: begin
               d.rdata[CTRL_CCSDS] = q.ccsds;
            end
            REG_STAT: begin
               d.rdata[POS_W-1:0] = seq_pos;
               d.rdata[STAT_CH +: CH_W] = seq_ch;
               d.rdata[STAT_PEND] = q.pend_have;
               d.rdata[STAT_PSEL +: PSEL_W] = q.blk_psel;
            end
            REG_POLY: begin
               d.rdata = 32'(POLY_USED);
            end
            REG_GEN: begin
               d.rdata[15:0] = 16'(GEN_START);
               d.rdata[GEN_SCALE +: 16] = 16'(SCALE_H);
            end
            REG_PDLY: begin
               d.rdata[23:0] = 24'(PD_MULTI);
               d.rdata[PDLY_SCALEOK] = SCALE_OK;
               d.rdata[PDLY_CONTOK] = CONT_OK;
            end
            REG_CODE: begin
               d.rdata[15:0] = 16'(BLK_N);
               // Fixed check count only, so no unlisted count can arrive
               d.rdata[CODE_R +: 16] = 16'(CHK_R);
            end
            REG_BLKS: begin
               d.rdata[15:0] = q.blocks;
            end
            default: begin
               d.rdata = '0;
            end
         endcase
      end
      d.arready = !d.rvalid;

      // One puncture selection held until the next block takes it
      if (s_axis_ctrl_tvalid && q.ctrl_ready && NUM_PUNC > 1) begin
         d.pend_have = 1'b1;
         d.pend_psel = puncture_pattern_select;
      end
      eff_psel = seq_first ? q.pend_psel : q.blk_psel;

      // Output register pair; pop shifts before the new entry lands
      if (pop) begin
         d.obuf[0] = q.obuf[1];
         d.olast[0] = q.olast[1];
         d.cnt = q.cnt - 2'd1;
      end
      slot = d.cnt;
      if (acc) begin
         if (seq_first) begin
            d.blk_psel = q.pend_psel;
            d.pend_have = 1'b0;
         end
         ent.ch = seq_ch;
         ent.erase = s_axis_input_tdata.erase
                     | punctured(seq_pos, eff_psel);
         // Conversion in, then straight back out; no decoding sits between them
         ent.sym = q.ccsds ? sym_back : s_axis_input_tdata.sym;
         d.obuf[slot[0]] = ent;
         d.olast[slot[0]] = seq_end;
         d.cnt = d.cnt + 2'd1;
         if (seq_end) begin
            d.blocks = q.blocks + 16'd1;
         end
      end
      d.ovalid = (d.cnt != 2'd0);

      // Ready is registered, so it looks at the next position
      fst_nxt = q.restart || d.restart || (acc ? seq_end : seq_first);
      need_ctrl = (NUM_PUNC > 1) && fst_nxt && !d.pend_have;
      d.in_ready = (d.cnt != 2'd2) && !need_ctrl && !d.restart;
      d.ctrl_ready = (NUM_PUNC <= 1) || !d.pend_have;
   end

   // ==========================================================
   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.ccsds <= CCSDS_RST;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs straight from state
   assign s_axi_awready        = q.awready;
   assign s_axi_wready         = q.wready;
   assign s_axi_bvalid         = q.bvalid;
   assign s_axi_bresp          = q.bresp;
   assign s_axi_arready        = q.arready;
   assign s_axi_rvalid         = q.rvalid;
   assign s_axi_rresp          = q.rresp;
   assign s_axi_rdata          = q.rdata;
   assign s_axis_ctrl_tready   = q.ctrl_ready;
   assign s_axis_input_tready  = q.in_ready;
   assign m_axis_output_tdata  = q.obuf[0];
   assign m_axis_output_tvalid = q.ovalid;
   assign m_axis_output_tlast  = q.olast[0];

   // ==========================================================
   // Helper: channel of the previous output symbol
   logic [CH_W-1:0] prev_ch;
   logic            prev_seen;
   always_ff @(posedge aclk) begin
      if (!aresetn || q.restart) begin
         prev_ch <= '0;
         prev_seen <= 1'b0;
      end else if (pop) begin
         prev_ch <= m_axis_output_tdata.ch;
         prev_seen <= !m_axis_output_tlast;
      end
   end

   // ==========================================================
   // Checks
   a_out_order: assert property (@(posedge aclk) disable iff (!aresetn)
      pop && prev_seen |-> m_axis_output_tdata.ch ==
         ((prev_ch == CH_W'(NUM_CH - 1)) ? '0 : prev_ch + 1'b1))
      else $error("output channel order broken");
   a_in_tagged: assert property (@(posedge aclk) disable iff (!aresetn)
      acc && q.cnt == 2'd0 |=> m_axis_output_tvalid
         && m_axis_output_tdata.ch == $past(seq_ch))
      else $error("input symbol not tagged with its channel");
   a_erase_own: assert property (@(posedge aclk) disable iff (!aresetn)
      acc && q.cnt == 2'd0 && s_axis_input_tdata.erase |=> m_axis_output_tdata.erase)
      else $error("erasure flag lost");
   a_ctrl_first: assert property (@(posedge aclk) disable iff (!aresetn)
      acc && seq_first && NUM_PUNC > 1 |-> q.pend_have)
      else $error("block started without a puncture selection");
   a_psel_block: assert property (@(posedge aclk) disable iff (!aresetn)
      !(acc && seq_first) |=> $stable(q.blk_psel))
      else $error("puncture selection changed inside a block");
   a_plain_sym: assert property (@(posedge aclk) disable iff (!aresetn)
      acc && q.cnt == 2'd0 && !q.ccsds
         |=> m_axis_output_tdata.sym == $past(s_axis_input_tdata.sym))
      else $error("custom mode altered a symbol");
   a_poly_read: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == REG_POLY
         |=> s_axi_rvalid && s_axi_rdata == 32'(POLY_USED))
      else $error("polynomial readback wrong");
   a_wr_resp: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |=> s_axi_bvalid)
      else $error("write response missing");
   a_out_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      m_axis_output_tvalid && !m_axis_output_tready
         |=> m_axis_output_tvalid && $stable(m_axis_output_tdata))
      else $error("output changed while stalled");

endmodule

// ---- testbench/rsdmc_sink.sv ----
// Downstream sink model with a selectable stall pattern
module rsdmc_sink (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Pace select and handshake
   input  wire logic slow,
   output logic      tready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt_q;
   // ====================
   // Slow mode takes one beat in four, so the shell buffer backs up
   always_ff @(posedge aclk) begin
      cnt_q  <= aresetn ? cnt_q + 2'h1 : 2'h0;
      tready <= aresetn && (!slow || cnt_q == 2'h3);
   end
endmodule

// ---- testbench/rsdmc_top_tb.sv ----
// Self-checking bench for the multichannel decoder stream shell
module rsdmc_top_tb
   import rsdmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
   logic psel = 1'b0, cv = 1'b0, iv = 1'b0, slow = 1'b0;
   logic [ADDR_W-1:0] awa = '0, ara = '0;
   logic [31:0]       wd = '0, r_d;
   logic [1:0]        b_r, r_r;
   logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, c_rdy, i_rdy, o_v, o_l, o_rdy;
   rsdmc_in_s         idat = '0;
   rsdmc_out_s        o_d;
   logic [11:0]       exp_q[$];
   int                bad_count = 0, checks_done = 0;
   localparam logic [7:0]  RA [6] = '{REG_POLY, REG_GEN, REG_PDLY, REG_CODE, REG_CTRL, 8'h40};
   localparam logic [31:0] RX [6] = '{32'h11d, 32'h1_0000, 32'hc000_0261, 32'h10_00ff, 0, 0};

   // ====================
   // Clock, design and sink
   always #4 aclk = ~aclk;
   rsdmc_top u_rsdmc_top (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(aw_rdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(w_rdy), .s_axi_bresp(b_r), .s_axi_bvalid(b_v), .s_axi_bready(1'b1),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ar_rdy), .s_axi_rdata(r_d),
      .s_axi_rresp(r_r), .s_axi_rvalid(r_v), .s_axi_rready(1'b1),
      .puncture_pattern_select(psel), .s_axis_ctrl_tvalid(cv), .s_axis_ctrl_tready(c_rdy),
      .s_axis_input_tdata(idat), .s_axis_input_tvalid(iv), .s_axis_input_tready(i_rdy),
      .m_axis_output_tdata(o_d), .m_axis_output_tvalid(o_v), .m_axis_output_tlast(o_l),
      .m_axis_output_tready(o_rdy));
   rsdmc_sink u_rsdmc_sink (.aclk(aclk), .aresetn(aresetn), .slow(slow), .tready(o_rdy));

   // ====================
   // Report and compare helpers
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Every handshake and drain wait goes through here, so a hang ends the run
   task automatic step(inout int n);
      @(posedge aclk);
      n++;
      if (n > 8000) begin
         chk("wait bound", 0, 1);
         wrap_up();
      end
   endtask

   // ====================
   // Register bus master, one access at a time
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic aw;
      logic w;
      {n, aw, w} = '0;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      do begin
         step(n);
         if (!aw && aw_rdy) awv <= 1'b0;
         if (!w && w_rdy) wv <= 1'b0;
         aw |= aw_rdy;
         w |= w_rdy;
      end while (!(aw && w && b_v));
      chk("write resp", 32'(er), 32'(b_r));
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      logic ar;
      {n, ar} = '0;
      ara <= a;
      arv <= 1'b1;
      do begin
         step(n);
         if (!ar && ar_rdy) arv <= 1'b0;
         ar |= ar_rdy;
      end while (!(ar && r_v));
      chk("read data", e, r_d);
      chk("read resp", 32'(er), 32'(r_r));
   endtask

   // ====================
   // Stream source: one selection, then all channels interlaced
   task automatic send_block(input logic sel, input bit gap, input int cnt);
      int n;
      n = 0;
      psel <= sel;
      cv <= 1'b1;
      do step(n); while (!c_rdy);
      cv <= 1'b0;
      for (int i = 0; i < cnt; i++) begin
         // Periodic valid gaps must not move the channel position
         if (gap && i % 10 == 5) begin
            iv <= 1'b0;
            @(posedge aclk);
         end
         idat <= '{erase: i % 7 == 3, sym: 8'(i * 5)};
         iv <= 1'b1;
         exp_q.push_back({i == BLK_N * NUM_CH - 1, CH_W'(i % 3),
                          (i % 7 == 3) || (sel && i / 3 >= 251), 8'(i * 5)});
         do step(n); while (!i_rdy);
      end
      iv <= 1'b0;
   endtask
   task automatic drain();
      int n;
      n = 0;
      while (exp_q.size() != 0) step(n);
   endtask

   // Output monitor, beats matched in order
   always @(posedge aclk) begin
      if (aresetn && o_v && o_rdy) begin
         if (exp_q.size() == 0) chk("extra beat", 0, 1);
         else chk("output beat", 32'(exp_q.pop_front()), 32'({o_l, o_d}));
      end
   end

   // ====================
   // Main sequence
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 6; i++) rd_chk(RA[i], RX[i], i == 5 ? RESP_SLVERR : RESP_OKAY);
      wr(REG_POLY, 32'h0, RESP_OKAY);
      wr(8'h40, 32'h1, RESP_SLVERR);
      rd_chk(REG_POLY, 32'h11d, RESP_OKAY);
      slow <= 1'b1;
      send_block(1'b1, 1'b1, BLK_N * NUM_CH);
      drain();
      rd_chk(REG_STAT, 32'h0100_0000, RESP_OKAY);
      wr(REG_CTRL, 32'h1, RESP_OKAY);
      rd_chk(REG_CTRL, 32'h1, RESP_OKAY);
      slow <= 1'b0;
      send_block(1'b0, 1'b0, BLK_N * NUM_CH);
      drain();
      rd_chk(REG_BLKS, 32'h2, RESP_OKAY);
      // Cut block, then a restart puts every channel back at block start
      send_block(1'b0, 1'b0, 10);
      drain();
      rd_chk(REG_STAT, 32'h0000_0103, RESP_OKAY);
      wr(REG_CTRL, 32'h3, RESP_OKAY);
      rd_chk(REG_STAT, 32'h0, RESP_OKAY);
      wrap_up();
   end
endmodule
